/* rtl/debug_acq_pkg.sv */
// Notes on behaviour
// - Operations accepted only after port acquisition
// - Acquisition window of 8 us after reset
// - Eight link clock edges extend window to 400 us
// - Host sends key on exactly one pair
// - Port pair or usb pair selectable
// - At most one pair active at a time
// - Host clocks one pin, other is bidirectional data
// - Trace output starts automatically with the port when debug is enabled
// - Trace carries watchpoint and instrumentation data
// - Debug off at reset, firmware write enables
// - Without debug only full erase recovers
// - Permanent lockout disables and rejects all access
// - Host holds port clock low for usb pair
package debug_acq_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int WIN_SHORT_NS = 8000;
  localparam int WIN_LONG_NS = 400000;
  // Longest times, so round down
  localparam int WIN_SHORT_CYC = WIN_SHORT_NS / CLK_PERIOD_NS;
  localparam int WIN_LONG_CYC = WIN_LONG_NS / CLK_PERIOD_NS;
  localparam int EDGE_EXTEND = 8;
  localparam int HOST_HALF_CYC = 4;
  localparam int PREAMBLE_SLOTS = 16;

  // ---------------------------------------------------------------
  // Link framing
  // ---------------------------------------------------------------
  localparam int KEY_BITS = 32;
  localparam int CMD_BITS = 8;
  localparam int SLOT_REPLY_LOAD = 8;
  localparam int SLOT_LAST = 16;
  localparam int TRACE_FRAME_BITS = 10;
  // Acquisition key; value is arbitrary
  localparam logic [31:0] ACQ_KEY = 32'h5A3C_96E1;
  localparam logic [7:0] CMD_ERASE = 8'hE5;
  localparam logic [7:0] REPLY_REFUSED = 8'h00;
  localparam logic PAIR_PORT = 1'b0;
  localparam logic PAIR_USB = 1'b1;

  typedef enum logic [2:0] {
    W_IDLE = 3'b000,
    W_SHORT = 3'b001,
    W_LONG = 3'b010,
    W_ACQ = 3'b011,
    W_CLOSED = 3'b100,
    W_LOCKED = 3'b101
  } win_state_type;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_PRE = 3'b001,
    H_KEY = 3'b010,
    H_READY = 3'b011,
    H_OP = 3'b100
  } host_state_type;

endpackage

/* rtl/debug_link_if.sv */
`timescale 1ns/1ps
interface debug_link_if;
  logic port_clk;
  logic usb_clk;
  logic port_dio_h_o;
  logic port_dio_h_oe;
  logic usb_dio_h_o;
  logic usb_dio_h_oe;
  logic port_dio_d_o;
  logic port_dio_d_oe;
  logic usb_dio_d_o;
  logic usb_dio_d_oe;
  logic port_dio;
  logic usb_dio;
  logic link_clk;
  logic trace_out;

  // ---------------------------------------------------------------
  // Wire resolution, pull-up when nobody drives
  // ---------------------------------------------------------------
  assign port_dio = port_dio_h_oe ? port_dio_h_o : (port_dio_d_oe ? port_dio_d_o : 1'b1);
  assign usb_dio = usb_dio_h_oe ? usb_dio_h_o : (usb_dio_d_oe ? usb_dio_d_o : 1'b1);
  // Port clock held low lets the usb clock through
  assign link_clk = port_clk | usb_clk;

  modport device (
    input link_clk,
    input port_dio,
    input usb_dio,
    output port_dio_d_o,
    output port_dio_d_oe,
    output usb_dio_d_o,
    output usb_dio_d_oe,
    output trace_out
  );

  modport host (
    output port_clk,
    output usb_clk,
    output port_dio_h_o,
    output port_dio_h_oe,
    output usb_dio_h_o,
    output usb_dio_h_oe,
    input port_dio,
    input usb_dio,
    input trace_out
  );
endinterface

/* rtl/debug_port_device.sv */
`timescale 1ns/1ps
module debug_port_device #(
  parameter int WIN_SHORT_CYCLES = debug_acq_pkg::WIN_SHORT_CYC,
  parameter int WIN_LONG_CYCLES = debug_acq_pkg::WIN_LONG_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic link_clk,
  debug_link_if.device link,
  input wire logic lockout_latch,
  input wire logic fw_debug_wr,
  input wire logic fw_debug_val,
  input wire logic watch_valid,
  input wire logic [7:0] watch_data,
  output logic watch_ready,
  input wire logic instr_valid,
  input wire logic [7:0] instr_data,
  output logic instr_ready,
  output logic port_acquired,
  output logic active_pair,
  output logic window_extended,
  output logic window_closed,
  output logic locked_out,
  output logic debug_enabled,
  output logic trace_active,
  output logic erase_req
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  debug_acq_pkg::win_state_type state_q;
  logic [15:0] cnt_q;
  logic win_open_q;
  logic ext_q;
  logic dbg_q;
  logic pair_q;
  logic acq_s1, acq_s2, acq_s3;
  logic pr_s1, pr_s2;
  logic e8_s1, e8_s2, e8_s3, e8_rise;
  logic er_s1, er_s2, er_s3;
  logic acq_rise;
  logic erase_pulse;
  // Link domain
  logic arm_l1, arm_l2, arm_p;
  logic dbg_l1, dbg_l2;
  logic fresh;
  logic [3:0] edge_q;
  logic e8_l_q;
  logic [31:0] sh_q [2];
  logic [1:0] match;
  logic [1:0] din;
  logic acq_l_q;
  logic pair_l_q;
  logic [4:0] slot_q;
  logic [7:0] cmd_q;
  logic [7:0] rep_q;
  logic drv_q;
  logic erase_tgl_q;
  logic [7:0] reply_d;
  logic din_sel;
  // Trace
  logic [9:0] tr_sh_q;
  logic [3:0] tr_cnt_q;
  logic trace_q;
  logic trace_on;

  // ---------------------------------------------------------------
  // Crossings into the system clock
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      acq_s1 <= 1'b1;
      acq_s2 <= 1'b1;
      acq_s3 <= 1'b1;
      pr_s1 <= 1'b0;
      pr_s2 <= 1'b0;
      e8_s1 <= 1'b1;
      e8_s2 <= 1'b1;
      e8_s3 <= 1'b1;
      er_s1 <= 1'b0;
      er_s2 <= 1'b0;
      er_s3 <= 1'b0;
    end else begin
      acq_s1 <= acq_l_q;
      acq_s2 <= acq_s1;
      acq_s3 <= acq_s2;
      pr_s1 <= pair_l_q;
      pr_s2 <= pr_s1;
      e8_s1 <= e8_l_q;
      e8_s2 <= e8_s1;
      e8_s3 <= e8_s2;
      er_s1 <= erase_tgl_q;
      er_s2 <= er_s1;
      er_s3 <= er_s2;
    end
  end

  // Link side keeps stale levels over reset; acq and e8 chains preset high so neither looks like a rise
  assign acq_rise = acq_s2 & ~acq_s3;
  assign e8_rise = e8_s2 & ~e8_s3;
  // Stale toggles before acquisition must not erase
  assign erase_pulse = (er_s2 ^ er_s3) & port_acquired;

  // ---------------------------------------------------------------
  // Acquisition window
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= debug_acq_pkg::W_IDLE;
    end else begin
      case (state_q)
        debug_acq_pkg::W_IDLE: begin
          // Lockout is caught in the first cycle after release
          if (lockout_latch) begin
            state_q <= debug_acq_pkg::W_LOCKED;
          end else begin
            state_q <= debug_acq_pkg::W_SHORT;
          end
        end
        debug_acq_pkg::W_SHORT: begin
          if (acq_rise) begin
            state_q <= debug_acq_pkg::W_ACQ;
          end else if (e8_rise) begin
            state_q <= debug_acq_pkg::W_LONG;
          end else if (cnt_q == 16'(WIN_SHORT_CYCLES - 1)) begin
            state_q <= debug_acq_pkg::W_CLOSED;
          end
        end
        debug_acq_pkg::W_LONG: begin
          if (acq_rise) begin
            state_q <= debug_acq_pkg::W_ACQ;
          end else if (cnt_q == 16'(WIN_LONG_CYCLES - 1)) begin
            state_q <= debug_acq_pkg::W_CLOSED;
          end
        end
        // Closed and locked hold until the next reset
        debug_acq_pkg::W_CLOSED: state_q <= debug_acq_pkg::W_CLOSED;
        debug_acq_pkg::W_LOCKED: state_q <= debug_acq_pkg::W_LOCKED;
        debug_acq_pkg::W_ACQ: state_q <= debug_acq_pkg::W_ACQ;
        default: state_q <= debug_acq_pkg::W_IDLE;
      endcase
    end
  end

  // Long window runs from reset, not from the extension
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_q <= 16'h0000;
    end else if (state_q == debug_acq_pkg::W_SHORT || state_q == debug_acq_pkg::W_LONG) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      win_open_q <= 1'b0;
      ext_q <= 1'b0;
      pair_q <= debug_acq_pkg::PAIR_PORT;
    end else begin
      win_open_q <= (state_q == debug_acq_pkg::W_SHORT) || (state_q == debug_acq_pkg::W_LONG);
      if (state_q == debug_acq_pkg::W_SHORT && e8_rise && !acq_rise) begin
        ext_q <= 1'b1;
      end
      if (acq_rise && win_open_q) begin
        pair_q <= pr_s2;
      end
    end
  end

  // Debug off after every reset; a full erase also drops it
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dbg_q <= 1'b0;
    end else if (erase_pulse) begin
      dbg_q <= 1'b0;
    end else if (fw_debug_wr) begin
      dbg_q <= fw_debug_val;
    end
  end

  // ---------------------------------------------------------------
  // Link logic
  // ---------------------------------------------------------------
  always_ff @(posedge link_clk) begin
    arm_l1 <= win_open_q;
    arm_l2 <= arm_l1;
    arm_p <= arm_l2;
    dbg_l1 <= dbg_q;
    dbg_l2 <= dbg_l1;
  end

  // Link clock stops outside frames, so its state is cleared on each window opening
  assign fresh = arm_l2 & ~arm_p;
  assign din = {link.usb_dio, link.port_dio};

  always_ff @(posedge link_clk) begin
    if (fresh) begin
      edge_q <= 4'h0;
      e8_l_q <= 1'b0;
    end else if (arm_l2 && edge_q != 4'(debug_acq_pkg::EDGE_EXTEND)) begin
      edge_q <= edge_q + 4'h1;
      e8_l_q <= (edge_q == 4'(debug_acq_pkg::EDGE_EXTEND - 1));
    end
  end

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pair
      always_ff @(posedge link_clk) begin
        if (fresh) begin
          sh_q[p] <= 32'h0000_0000;
        end else begin
          sh_q[p] <= {din[p], sh_q[p][31:1]};
        end
      end
      assign match[p] = ({din[p], sh_q[p][31:1]} == debug_acq_pkg::ACQ_KEY);
    end
  endgenerate

  // First pair to match wins; the other is never served
  always_ff @(posedge link_clk) begin
    if (fresh) begin
      acq_l_q <= 1'b0;
      pair_l_q <= debug_acq_pkg::PAIR_PORT;
    end else if (arm_l2 && !acq_l_q && (match != 2'b00)) begin
      acq_l_q <= 1'b1;
      pair_l_q <= match[0] ? debug_acq_pkg::PAIR_PORT : debug_acq_pkg::PAIR_USB;
    end
  end

  assign din_sel = pair_l_q ? link.usb_dio : link.port_dio;

  always_comb begin
    if (dbg_l2 || cmd_q == debug_acq_pkg::CMD_ERASE) begin
      reply_d = {dbg_l2, pair_l_q, 1'b1, cmd_q[4:0]};
    end else begin
      reply_d = debug_acq_pkg::REPLY_REFUSED;
    end
  end

  // Command in on slots 0..7, turnaround, reply out on slots 9..16
  always_ff @(posedge link_clk) begin
    if (fresh) begin
      slot_q <= 5'h00;
      drv_q <= 1'b0;
      cmd_q <= 8'h00;
      rep_q <= 8'h00;
      erase_tgl_q <= 1'b0;
    end else if (acq_l_q) begin
      slot_q <= (slot_q == 5'(debug_acq_pkg::SLOT_LAST)) ? 5'h00 : slot_q + 5'h01;
      if (slot_q < 5'(debug_acq_pkg::CMD_BITS)) begin
        cmd_q <= {din_sel, cmd_q[7:1]};
      end
      if (slot_q == 5'(debug_acq_pkg::SLOT_REPLY_LOAD)) begin
        rep_q <= reply_d;
        drv_q <= 1'b1;
        if (cmd_q == debug_acq_pkg::CMD_ERASE) begin
          erase_tgl_q <= ~erase_tgl_q;
        end
      end else if (slot_q == 5'(debug_acq_pkg::SLOT_LAST)) begin
        drv_q <= 1'b0;
      end else begin
        rep_q <= {1'b0, rep_q[7:1]};
      end
    end
  end

  // Pins driven only on the one acquired pair, never under lockout
  assign link.port_dio_d_oe = port_acquired && (pair_q == debug_acq_pkg::PAIR_PORT) && drv_q;
  assign link.usb_dio_d_oe = port_acquired && (pair_q == debug_acq_pkg::PAIR_USB) && drv_q;
  assign link.port_dio_d_o = link.port_dio_d_oe & rep_q[0];
  assign link.usb_dio_d_o = link.usb_dio_d_oe & rep_q[0];

  // ---------------------------------------------------------------
  // Trace serializer
  // ---------------------------------------------------------------
  assign trace_on = port_acquired && dbg_q;
  assign watch_ready = trace_on && (tr_cnt_q == 4'h0);
  assign instr_ready = trace_on && (tr_cnt_q == 4'h0) && !watch_valid;

  // Start bit, eight bits LSB first, stop bit; watchpoints take priority
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tr_sh_q <= 10'h3FF;
      tr_cnt_q <= 4'h0;
      trace_q <= 1'b1;
    end else if (tr_cnt_q != 4'h0) begin
      trace_q <= tr_sh_q[0];
      tr_sh_q <= {1'b1, tr_sh_q[9:1]};
      tr_cnt_q <= tr_cnt_q - 4'h1;
    end else if (watch_valid && watch_ready) begin
      tr_sh_q <= {1'b1, watch_data, 1'b0};
      tr_cnt_q <= 4'(debug_acq_pkg::TRACE_FRAME_BITS);
      trace_q <= 1'b1;
    end else if (instr_valid && instr_ready) begin
      tr_sh_q <= {1'b1, instr_data, 1'b0};
      tr_cnt_q <= 4'(debug_acq_pkg::TRACE_FRAME_BITS);
      trace_q <= 1'b1;
    end else begin
      trace_q <= 1'b1;
    end
  end

  assign link.trace_out = trace_q;

  // ---------------------------------------------------------------
  // Status
  // ---------------------------------------------------------------
  assign port_acquired = (state_q == debug_acq_pkg::W_ACQ);
  assign active_pair = pair_q;
  assign window_extended = ext_q;
  assign window_closed = (state_q == debug_acq_pkg::W_CLOSED);
  assign locked_out = (state_q == debug_acq_pkg::W_LOCKED);
  assign debug_enabled = dbg_q;
  assign trace_active = port_acquired;
  assign erase_req = erase_pulse;

endmodule

/* rtl/debug_port_host.sv */
`timescale 1ns/1ps
module debug_port_host (
  input wire logic clk,
  input wire logic resetn,
  debug_link_if.host link,
  input wire logic acquire_start,
  input wire logic acquire_pair,
  output logic busy,
  output logic op_ready,
  input wire logic op_valid,
  input wire logic [7:0] op_cmd,
  output logic reply_valid,
  output logic [7:0] reply_data
);

  debug_acq_pkg::host_state_type st_q;
  logic [2:0] ph_q;
  logic [5:0] slot_q;
  logic pair_q;
  logic [31:0] sh_q;
  logic [7:0] rep_q;
  logic rv_q;
  logic pclk_q, uclk_q;
  logic p1, p2, u1, u2;
  logic slot_end;
  logic tx;
  logic din;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    p1 <= link.port_dio;
    p2 <= p1;
    u1 <= link.usb_dio;
    u2 <= u1;
  end

  assign din = pair_q ? u2 : p2;
  assign slot_end = (ph_q == 3'(2 * debug_acq_pkg::HOST_HALF_CYC - 1));

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= debug_acq_pkg::H_IDLE;
      ph_q <= 3'h0;
      slot_q <= 6'h00;
      pair_q <= debug_acq_pkg::PAIR_PORT;
      sh_q <= 32'h0000_0000;
      rep_q <= 8'h00;
      rv_q <= 1'b0;
    end else begin
      rv_q <= 1'b0;
      case (st_q)
        debug_acq_pkg::H_IDLE, debug_acq_pkg::H_READY: begin
          ph_q <= 3'h0;
          slot_q <= 6'h00;
          if (acquire_start) begin
            pair_q <= acquire_pair;
            sh_q <= 32'h0000_0000;
            st_q <= debug_acq_pkg::H_PRE;
          end else if (op_valid && st_q == debug_acq_pkg::H_READY) begin
            sh_q <= {24'h00_0000, op_cmd};
            st_q <= debug_acq_pkg::H_OP;
          end
        end
        default: begin
          ph_q <= ph_q + 3'h1;
          // Reply bit k is sampled just before the rising edge of slot 9+k
          if (st_q == debug_acq_pkg::H_OP && ph_q == 3'h0 && slot_q > 6'h08) begin
            rep_q <= {din, rep_q[7:1]};
          end
          if (slot_end) begin
            slot_q <= slot_q + 6'h01;
            sh_q <= {1'b0, sh_q[31:1]};
            if (st_q == debug_acq_pkg::H_PRE &&
                slot_q == 6'(debug_acq_pkg::PREAMBLE_SLOTS - 1)) begin
              sh_q <= debug_acq_pkg::ACQ_KEY;
              slot_q <= 6'h00;
              st_q <= debug_acq_pkg::H_KEY;
            end else if (st_q == debug_acq_pkg::H_KEY &&
                         slot_q == 6'(debug_acq_pkg::KEY_BITS - 1)) begin
              st_q <= debug_acq_pkg::H_READY;
            end else if (st_q == debug_acq_pkg::H_OP &&
                         slot_q == 6'(debug_acq_pkg::SLOT_LAST)) begin
              rv_q <= 1'b1;
              st_q <= debug_acq_pkg::H_READY;
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Link clock, high for the second half of each slot
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pclk_q <= 1'b0;
      uclk_q <= 1'b0;
    end else if (st_q == debug_acq_pkg::H_PRE || st_q == debug_acq_pkg::H_KEY ||
                 st_q == debug_acq_pkg::H_OP) begin
      if (ph_q == 3'(debug_acq_pkg::HOST_HALF_CYC - 1)) begin
        pclk_q <= (pair_q == debug_acq_pkg::PAIR_PORT);
        uclk_q <= (pair_q == debug_acq_pkg::PAIR_USB);
      end else if (slot_end) begin
        pclk_q <= 1'b0;
        uclk_q <= 1'b0;
      end
    end else begin
      pclk_q <= 1'b0;
      uclk_q <= 1'b0;
    end
  end

  // Unused pair stays quiet, port clock low keeps the usb clock visible
  assign link.port_clk = pclk_q;
  assign link.usb_clk = uclk_q;
  assign tx = (st_q == debug_acq_pkg::H_PRE) || (st_q == debug_acq_pkg::H_KEY) ||
              (st_q == debug_acq_pkg::H_OP && slot_q < 6'(debug_acq_pkg::CMD_BITS));
  assign link.port_dio_h_oe = tx && (pair_q == debug_acq_pkg::PAIR_PORT);
  assign link.usb_dio_h_oe = tx && (pair_q == debug_acq_pkg::PAIR_USB);
  assign link.port_dio_h_o = sh_q[0];
  assign link.usb_dio_h_o = sh_q[0];

  assign busy = (st_q != debug_acq_pkg::H_IDLE) && (st_q != debug_acq_pkg::H_READY);
  assign op_ready = (st_q == debug_acq_pkg::H_READY);
  assign reply_valid = rv_q;
  assign reply_data = rep_q;

endmodule

/* verification/debug_port_acquisition_checker.sv */
`timescale 1ns/1ps
module debug_port_acquisition_checker #(
  parameter int WIN_SHORT_CYCLES = 320,
  parameter int WIN_LONG_CYCLES = 2000
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic port_clk,
  input wire logic usb_clk,
  input wire logic port_dio_h_oe,
  input wire logic usb_dio_h_oe,
  input wire logic port_dio_d_oe,
  input wire logic usb_dio_d_oe,
  input wire logic trace_out,
  input wire logic port_acquired,
  input wire logic active_pair,
  input wire logic window_extended,
  input wire logic window_closed,
  input wire logic locked_out,
  input wire logic debug_enabled,
  input wire logic trace_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ---------------------------------------------------------------
  // Age since reset release, saturating so it never wraps
  // ---------------------------------------------------------------
  logic [15:0] age_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      age_q <= 16'h0000;
    end else if (age_q != 16'hFFFF) begin
      age_q <= age_q + 16'h0001;
    end
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  sequence s_no_drive;
    !port_dio_d_oe && !usb_dio_d_oe;
  endsequence
  sequence s_quiet;
    !port_acquired && !debug_enabled && trace_out ##0 s_no_drive;
  endsequence
  property p_reset_quiet;
    disable iff (1'b0) !resetn |=> s_quiet;
  endproperty
  property p_no_drive_unacq;
    !port_acquired |-> s_no_drive;
  endproperty
  property p_one_pair;
    !(port_dio_d_oe && usb_dio_d_oe);
  endproperty
  property p_pair_drive;
    (port_dio_d_oe || usb_dio_d_oe) |-> active_pair == usb_dio_d_oe;
  endproperty
  property p_acq_hold;
    port_acquired |=> port_acquired;
  endproperty
  property p_short_len;
    window_closed && !window_extended |-> age_q >= 16'(WIN_SHORT_CYCLES);
  endproperty
  property p_short_end;
    !window_extended && !port_acquired && !locked_out && age_q > 16'(WIN_SHORT_CYCLES + 8)
      |-> window_closed;
  endproperty
  property p_long_end;
    window_extended && !port_acquired && age_q > 16'(WIN_LONG_CYCLES + 8) |-> window_closed;
  endproperty
  property p_ext_open;
    $rose(window_extended) |-> !window_closed && !locked_out;
  endproperty
  property p_lock;
    locked_out |-> (!port_acquired && !window_extended) ##0 s_no_drive;
  endproperty
  property p_closed;
    window_closed && !port_acquired |=> !port_acquired [*8];
  endproperty
  property p_trace_auto;
    trace_active == port_acquired;
  endproperty
  property p_trace_idle;
    !port_acquired |-> trace_out;
  endproperty
  property p_one_host_pair;
    !(port_dio_h_oe && usb_dio_h_oe);
  endproperty
  property p_usb_clk_alone;
    usb_clk |-> !port_clk;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("not quiet in reset");
  a_no_drive_unacq: assert property (p_no_drive_unacq) else $error("drive unacquired");
  a_one_pair: assert property (p_one_pair) else $error("both pairs driven");
  a_pair_drive: assert property (p_pair_drive) else $error("wrong pair driven");
  a_acq_hold: assert property (p_acq_hold) else $error("acquisition lost");
  a_short_len: assert property (p_short_len) else $error("short window early");
  a_short_end: assert property (p_short_end) else $error("short window late");
  a_long_end: assert property (p_long_end) else $error("long window late");
  a_ext_open: assert property (p_ext_open) else $error("extension when shut");
  a_lock: assert property (p_lock) else $error("access under lockout");
  a_closed: assert property (p_closed) else $error("acquired after close");
  a_trace_auto: assert property (p_trace_auto) else $error("trace not with port");
  a_trace_idle: assert property (p_trace_idle) else $error("trace not idle");
  a_one_host_pair: assert property (p_one_host_pair) else $error("host on two pairs");
  a_usb_clk_alone: assert property (p_usb_clk_alone) else $error("port clock not low");
endmodule

/* verification/debug_port_acquisition_tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module debug_port_acquisition_tb_top;
  localparam int SHORT = 320;
  localparam int LONG = 2000;
  logic clk = 1'b0, resetn = 1'b0, lockout_latch = 1'b0, fw_debug_wr = 1'b0;
  logic fw_debug_val = 1'b0, watch_valid = 1'b0, instr_valid = 1'b0;
  logic acquire_start = 1'b0, acquire_pair = 1'b0, op_valid = 1'b0;
  logic [7:0] watch_data = 8'h00, instr_data = 8'h00, op_cmd = 8'h00;
  logic watch_ready, instr_ready, port_acquired, active_pair, window_extended;
  logic window_closed, locked_out, debug_enabled, trace_active, erase_req;
  logic busy, op_ready, reply_valid, p;
  logic [7:0] reply_data, r, c;
  logic [9:0] fr;
  int failures = 0, check_count = 0, erase_cnt = 0, e;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (erase_req === 1'b1) erase_cnt++;
  debug_link_if link ();
  debug_port_device #(.WIN_SHORT_CYCLES(SHORT), .WIN_LONG_CYCLES(LONG)) u_debug_port_device (
    .clk(clk), .resetn(resetn), .link_clk(link.link_clk), .link(link),
    .lockout_latch(lockout_latch), .fw_debug_wr(fw_debug_wr), .fw_debug_val(fw_debug_val),
    .watch_valid(watch_valid), .watch_data(watch_data), .watch_ready(watch_ready),
    .instr_valid(instr_valid), .instr_data(instr_data), .instr_ready(instr_ready),
    .port_acquired(port_acquired), .active_pair(active_pair),
    .window_extended(window_extended), .window_closed(window_closed),
    .locked_out(locked_out), .debug_enabled(debug_enabled), .trace_active(trace_active),
    .erase_req(erase_req));
  debug_port_host u_debug_port_host (
    .clk(clk), .resetn(resetn), .link(link), .acquire_start(acquire_start),
    .acquire_pair(acquire_pair), .busy(busy), .op_ready(op_ready), .op_valid(op_valid),
    .op_cmd(op_cmd), .reply_valid(reply_valid), .reply_data(reply_data));
  debug_port_acquisition_checker #(.WIN_SHORT_CYCLES(SHORT), .WIN_LONG_CYCLES(LONG)) u_chk (
    .clk(clk), .resetn(resetn), .port_clk(link.port_clk), .usb_clk(link.usb_clk),
    .port_dio_h_oe(link.port_dio_h_oe), .usb_dio_h_oe(link.usb_dio_h_oe),
    .port_dio_d_oe(link.port_dio_d_oe), .usb_dio_d_oe(link.usb_dio_d_oe),
    .trace_out(link.trace_out), .port_acquired(port_acquired), .active_pair(active_pair),
    .window_extended(window_extended), .window_closed(window_closed),
    .locked_out(locked_out), .debug_enabled(debug_enabled), .trace_active(trace_active));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_reset(input logic lock);
    resetn = 1'b0;
    lockout_latch = lock;
    step(4);
    resetn = 1'b1;
  endtask
  task automatic acquire(input logic pair);
    int i;
    acquire_start = 1'b1;
    acquire_pair = pair;
    step(1);
    acquire_start = 1'b0;
    for (i = 0; i < 1000 && busy !== 1'b0; i++) step(1);
    `CHK("busy", 1'b0, busy)
    // Margin for the link-to-core synchroniser
    step(20);
  endtask
  task automatic op(input logic [7:0] cmd);
    int i;
    for (i = 0; i < 50 && op_ready !== 1'b1; i++) step(1);
    op_valid = 1'b1;
    op_cmd = cmd;
    step(1);
    op_valid = 1'b0;
    for (i = 0; i < 300 && reply_valid !== 1'b1; i++) step(1);
    `CHK("reply_valid", 1'b1, reply_valid)
    r = reply_data;
  endtask
  task automatic trace(input logic src, input logic [7:0] d);
    int i;
    if (src) begin
      instr_valid = 1'b1;
      instr_data = d;
    end else begin
      watch_valid = 1'b1;
      watch_data = d;
    end
    for (i = 0; i < 20 && (src ? instr_ready : watch_ready) !== 1'b1; i++) step(1);
    step(1);
    watch_valid = 1'b0;
    instr_valid = 1'b0;
    for (i = 0; i < 6 && link.trace_out !== 1'b0; i++) step(1);
    for (i = 0; i < 10; i++) begin
      fr[i] = link.trace_out;
      step(1);
    end
    `CHK("trace_frame", {1'b1, d, 1'b0}, fr)
  endtask
  function automatic logic [7:0] exp_reply(input logic [7:0] cmd, input logic en, input logic pr);
    if (!en && cmd != debug_acq_pkg::CMD_ERASE) return debug_acq_pkg::REPLY_REFUSED;
    return {en, pr, 1'b1, cmd[4:0]};
  endfunction
  function automatic logic [7:0] rnd_cmd();
    logic [7:0] v;
    v = 8'($urandom);
    if (v == debug_acq_pkg::CMD_ERASE) v = 8'h15;
    return v;
  endfunction
  task automatic summarize();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    step(30000);
    failures++;
    summarize();
  end
  initial begin
    void'($urandom(3943));
    for (int k = 0; k < 2; k++) begin
      p = k[0];
      do_reset(1'b0);
      acquire(p);
      `CHK("acquired", 1'b1, port_acquired)
      `CHK("pair", p, active_pair)
      `CHK("extended", 1'b1, window_extended)
      `CHK("trace_on", 1'b1, trace_active)
      `CHK("debug_off", 1'b0, debug_enabled)
      c = rnd_cmd();
      op(c);
      `CHK("reply_off", exp_reply(c, 1'b0, p), r)
      fw_debug_val = 1'b1;
      fw_debug_wr = 1'b1;
      step(1);
      fw_debug_wr = 1'b0;
      step(2);
      `CHK("debug_on", 1'b1, debug_enabled)
      for (int j = 0; j < 4; j++) begin
        c = (j == 0) ? 8'h00 : (j == 1) ? 8'hFF : rnd_cmd();
        op(c);
        `CHK("reply_on", exp_reply(c, 1'b1, p), r)
      end
      trace(1'b0, 8'h00);
      trace(1'b1, 8'hFF);
      trace(1'b0, 8'($urandom));
      trace(1'b1, 8'($urandom));
      e = erase_cnt;
      `CHK("no_stale_erase", k, e)
      op(debug_acq_pkg::CMD_ERASE);
      step(4);
      `CHK("erase_pulse", e + 1, erase_cnt)
      `CHK("debug_cleared", 1'b0, debug_enabled)
      c = rnd_cmd();
      op(c);
      `CHK("reply_erased", exp_reply(c, 1'b0, p), r)
    end
    // Idle link: no clocks, so the short window must lapse
    do_reset(1'b0);
    step(SHORT + 20);
    `CHK("closed", 1'b1, window_closed)
    `CHK("not_extended", 1'b0, window_extended)
    acquire(1'b0);
    `CHK("late_acquire", 1'b0, port_acquired)
    op(rnd_cmd());
    `CHK("late_reply", 8'hFF, r)
    do_reset(1'b1);
    step(2);
    `CHK("locked", 1'b1, locked_out)
    acquire(1'b1);
    `CHK("locked_acquire", 1'b0, port_acquired)
    op(rnd_cmd());
    `CHK("locked_reply", 8'hFF, r)
    summarize();
  end
endmodule
